// ===== tb/gripper_status_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gripper_status_registers_tb;
	logic       clk_i, rstn_i, act, gto, rel, ev, cal, mov, con, clo, rdn;
	logic       otp, uvl, inf, acf, ocr, quiet, red, blue, rg, prev_red;
	logic [7:0] pos, frc, mpos, cur, rdat, d;
	logic [3:0] ext, addr;
	logic [1:0] fm;
	int         num_errors, comparisons, n;
	logic [7:0] vals [5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
	logic [2:0] fexp [5] = '{3'h0, 3'h5, 3'h5, 3'h6, 3'h6};

	grs_status #(.COMM_TIMEOUT(50), .BLINK_HALF(4)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.activate_request_i(act), .goto_request_i(gto), .auto_release_i(rel),
		.position_request_i(pos), .force_request_i(frc), .comm_event_i(ev), .calib_done_i(cal),
		.moving_i(mov), .contact_i(con), .closing_i(clo), .release_done_i(rdn), .overtemp_i(otp),
		.undervolt_i(uvl), .internal_fault_i(inf), .act_fault_i(acf), .overcurrent_i(ocr),
		.external_controller_fault_i(ext), .measured_position_i(mpos), .motor_current_sample_i(cur),
		.rd_addr_i(addr), .rd_data_o(rdat), .force_mode_o(fm), .regrasp_en_o(rg),
		.led_red_o(red), .led_blue_o(blue));
	grs_ctl_model ctl_u (.clk_i(clk_i), .rd_data_i(rdat), .quiet_i(quiet), .rd_addr_o(addr),
		.comm_event_o(ev));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic step(input int k);
		repeat (k) @(negedge clk_i);
	endtask : step
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		ctl_u.rd(a, d);
		chk(d, e);
	endtask : rchk
	task automatic react;
		act = 0;
		cal = 0;
		step(2);
		act = 1;
		step(2);
		cal = 1;
		step(2);
	endtask : react
	task automatic summarize;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic t_act;
		rchk(4'h0, 8'h00);
		chk({6'h0, red, blue}, 8'h01);
		act = 1;
		step(1);
		rchk(4'h0, 8'h11);
		cal = 1;
		step(1);
		rchk(4'h0, 8'h31);
		$display("t_act done");
	endtask : t_act
	task automatic t_obj;
		gto = 1;
		mov = 1;
		step(1);
		rchk(4'h0, 8'h39);
		{con, clo, mov} = 3'b110;
		rchk(4'h0, 8'hb9);
		clo = 0;
		rchk(4'h0, 8'h79);
		con = 0;
		rchk(4'h0, 8'hf9);
		gto = 0;
		ctl_u.rd(4'h0, d);
		chk(d, 8'h31);
		chk({6'h0, ctl_u.obj_valid(d)}, 8'h00);
		$display("t_obj done");
	endtask : t_obj
	task automatic t_bytes;
		for (int i = 0; i < 5; i++) begin
			pos = vals[i];
			mpos = ~vals[i];
			cur = vals[i] ^ 8'h3c;
			ext = vals[i][3:0];
			rchk(4'h3, vals[i]);
			rchk(4'h4, ~vals[i]);
			rchk(4'h5, vals[i] ^ 8'h3c);
			rchk(4'h2, {vals[i][3:0], 4'h0});
		end
		ext = 0;
		rchk(4'h1, 8'h00);
		rchk(4'h6, 8'h00);
		rchk(4'hf, 8'h00);
		$display("t_bytes done");
	endtask : t_bytes
	task automatic t_force;
		for (int i = 0; i < 5; i++) begin
			frc = vals[i];
			step(2);
			chk({5'h0, rg, fm}, {5'h0, fexp[i]});
		end
		$display("t_force done");
	endtask : t_force
	task automatic t_flt;
		otp = 1;
		step(3);
		rchk(4'h2, 8'h08);
		step(5);
		chk({6'h0, red, blue}, 8'h02);
		otp = 0;
		step(3);
		rchk(4'h2, 8'h00);
		quiet = 1;
		step(60);
		rchk(4'h2, 8'h09);
		quiet = 0;
		step(20);
		rchk(4'h2, 8'h00);
		for (int i = 0; i < 4; i++) begin
			{uvl, inf, acf, ocr} = 4'h8 >> i;
			step(3);
			{uvl, inf, acf, ocr} = 4'h0;
			step(3);
			ctl_u.rd(4'h0, d);
			chk(d, 8'h01);
			chk({7'h0, ctl_u.fault_due(d)}, 8'h01);
			rchk(4'h2, (i == 0) ? 8'h0a : 8'(8'h0b + i));
			n = 0;
			for (int k = 0; k < 8; k++) begin
				prev_red = red;
				step(1);
				n += (prev_red !== red);
			end
			chk(n[7:0], 8'h02);
			chk({7'h0, red ^ blue}, 8'h01);
			act = 0;
			step(1);
			rchk(4'h2, 8'h00);
			react();
		end
		rel = 1;
		step(1);
		rchk(4'h2, 8'h0b);
		rdn = 1;
		step(1);
		rchk(4'h2, 8'h0f);
		{rel, rdn} = 2'b00;
		act = 0;
		gto = 1;
		step(1);
		rchk(4'h2, 8'h07);
		cal = 0;
		act = 1;
		step(1);
		rchk(4'h2, 8'h05);
		$display("t_flt done");
	endtask : t_flt

	initial begin
		num_errors = 0;
		comparisons = 0;
		rstn_i = 0;
		{act, gto, rel, cal, mov, con, clo, rdn, otp, uvl, inf, acf, ocr, quiet} = '0;
		{pos, frc, mpos, cur, ext} = '0;
		step(6);
		rstn_i = 1;
		step(1);
		t_act();
		t_obj();
		t_bytes();
		t_force();
		t_flt();
		summarize();
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		num_errors++;
		summarize();
	end
endmodule : gripper_status_registers_tb
`default_nettype wire

// ===== tb/grs_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module grs_ctl_model (
	input  wire logic       clk_i,       // System clock
	input  wire logic [7:0] rd_data_i,   // Status byte
	input  wire logic       quiet_i,     // Stop keep-alive
	output logic      [3:0] rd_addr_o,   // Status byte index
	output logic            comm_event_o // Message pulse
);
	int gap;
	// Keep-alive message every 16 cycles, well inside the shortened watchdog
	initial begin
		rd_addr_o = 4'h0;
		comm_event_o = 1'b0;
		gap = 0;
		forever begin
			@(negedge clk_i);
			gap = gap + 1;
			comm_event_o = !quiet_i && (gap % 16 == 0);
		end
	end
	// Address held through the capture edge; data taken half a cycle later
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk_i);
		rd_addr_o = a;
		@(negedge clk_i);
		d = rd_data_i;
	endtask : rd
	function automatic logic [1:0] obj_valid(input logic [7:0] b);
		return b[3] ? b[7:6] : 2'h0;
	endfunction : obj_valid
	function automatic logic fault_due(input logic [7:0] b);
		return b[0] && b[5:4] == 2'h0;
	endfunction : fault_due
endmodule : grs_ctl_model
`default_nettype wire

// ===== verilog/grs_pkg.sv
`default_nettype none
package grs_pkg;
	// Status byte offsets
	localparam logic [3:0] OFF_STATE    = 4'h0;
	localparam logic [3:0] OFF_SPARE    = 4'h1;
	localparam logic [3:0] OFF_FAULT    = 4'h2;
	localparam logic [3:0] OFF_TGT_ECHO = 4'h3;
	localparam logic [3:0] OFF_MEAS_POS = 4'h4;
	localparam logic [3:0] OFF_CURRENT  = 4'h5;
	// Field positions in the state byte
	localparam int BIT_ACT  = 0;
	localparam int BIT_GOTO = 3;
	localparam int POS_MOT  = 4;
	localparam int POS_OBJ  = 6;
	// Motion state codes
	localparam logic [1:0] MOT_RESET  = 2'h0;
	localparam logic [1:0] MOT_ACTING = 2'h1;
	localparam logic [1:0] MOT_DONE   = 2'h3;
	// Object detection codes
	localparam logic [1:0] OBJ_MOVING = 2'h0;
	localparam logic [1:0] OBJ_OPEN   = 2'h1;
	localparam logic [1:0] OBJ_CLOSE  = 2'h2;
	localparam logic [1:0] OBJ_AT_POS = 2'h3;
	// Fault codes
	localparam logic [3:0] FLT_NONE     = 4'h0;
	localparam logic [3:0] FLT_DELAYED  = 4'h5;
	localparam logic [3:0] FLT_NO_ACT   = 4'h7;
	localparam logic [3:0] FLT_TEMP     = 4'h8;
	localparam logic [3:0] FLT_NO_COMM  = 4'h9;
	localparam logic [3:0] FLT_UNDERV   = 4'ha;
	localparam logic [3:0] FLT_REL_RUN  = 4'hb;
	localparam logic [3:0] FLT_INTERNAL = 4'hc;
	localparam logic [3:0] FLT_ACT_FAIL = 4'hd;
	localparam logic [3:0] FLT_OVERCUR  = 4'he;
	localparam logic [3:0] FLT_REL_DONE = 4'hf;
	localparam logic [3:0] FLT_MAJOR_MIN = 4'ha;
	// Force modes
	localparam logic [7:0] FORCE_HIGH_MIN = 8'h80;
	// Timing
	localparam int CLK_HZ         = 125000000;
	localparam int COMM_TIMEOUT_S = 1;
	localparam int COMM_TIMEOUT_CYC = CLK_HZ * COMM_TIMEOUT_S;
	localparam int BLINK_CYC      = 62500000;
	// Indicator codes: 0 blue, 1 red, 2 blink
	typedef enum logic [1:0] {
		GRS_LED_BLUE,
		GRS_LED_RED,
		GRS_LED_BLINK
	} grs_led_t;
	typedef enum logic [1:0] {
		GRS_FM_FRAGILE,
		GRS_FM_LOW,
		GRS_FM_HIGH
	} grs_force_mode_t;
endpackage : grs_pkg
`default_nettype wire

// ===== verilog/grs_status.sv
// Contract
// - State byte bit 0 echoes the activate request.
// - Go-to echo bit follows the go-to request bit.
// - Motion state: 0 reset/release, 1 activating, 3 activated; never 2.
// - Object field 0 while travelling, 3 at target or object lost.
// - Object field 1 on contact stop while opening.
// - Object field 2 on contact stop while closing.
// - Object field sits in bits 7:6 of state byte.
// - Fault 5 for action held during activation, 7 for action unactivated.
// - Fault 8 on overtemperature, indicator steady red.
// - Fault 9 after one second without communication.
// - Major faults latch until activate is cleared; indicator blinks.
// - Fault 10 on undervoltage.
// - Fault 11 during auto release, 15 once it finished.
// - Fault 12 internal, 13 activation fail, 14 overcurrent, 0 none.
// - Byte 3 echoes requested position.
// - Byte 4 holds encoder position.
// - Byte 5 holds motor current sample, ten mA per count.
// - Force zero gives fragile mode without re-grasp.
// - Force 1 to 127 gives low torque with re-grasp.
// - Force 128 to 255 gives high torque with re-grasp.
// - Clearing activate returns to reset and clears the fault code, or sets it to 7 while go-to or auto release is set.
`timescale 1ns/1ps
`default_nettype none
module grs_status #(
	parameter int COMM_TIMEOUT = grs_pkg::COMM_TIMEOUT_CYC,
	parameter int BLINK_HALF   = grs_pkg::BLINK_CYC
) (
	input  wire logic       clk_i,             // System clock, 125 MHz
	input  wire logic       rstn_i,            // Sync reset, active low
	input  wire logic       activate_request_i, // Command byte activate bit
	input  wire logic       goto_request_i,    // Command byte go-to bit
	input  wire logic       auto_release_i,    // Command byte auto release bit
	input  wire logic [7:0] position_request_i, // Requested position
	input  wire logic [7:0] force_request_i,   // Requested force
	input  wire logic       comm_event_i,      // Pulse per received message
	input  wire logic       calib_done_i,      // Activation routine finished
	input  wire logic       moving_i,          // Fingers in motion
	input  wire logic       contact_i,         // Current limit stop
	input  wire logic       closing_i,         // Direction of current move
	input  wire logic       release_done_i,    // Auto release at end stops
	input  wire logic       overtemp_i,        // Pin: temperature alarm
	input  wire logic       undervolt_i,       // Pin: supply low
	input  wire logic       internal_fault_i,  // Internal error pulse
	input  wire logic       act_fault_i,       // Activation failed pulse
	input  wire logic       overcurrent_i,     // Pin: overcurrent
	input  wire logic [3:0] external_controller_fault_i, // External code
	input  wire logic [7:0] measured_position_i, // Encoder position
	input  wire logic [7:0] motor_current_sample_i, // Current sample
	input  wire logic [3:0] rd_addr_i,         // Status byte index
	output logic      [7:0] rd_data_o,         // Status byte read data
	output logic      [1:0] force_mode_o,      // Selected torque mode
	output logic            regrasp_en_o,      // Re-grasp enabled
	output logic            led_red_o,         // Indicator red
	output logic            led_blue_o         // Indicator blue
);
	logic [2:0] pins_s;
	logic       overtemp_s;
	logic       undervolt_s;
	logic       overcur_s;
	logic       act_q;
	logic       act_rise;
	logic       comm_lost;
	logic [1:0] motion_state;
	logic [1:0] object_detect_state;
	logic [3:0] fault_code;
	logic [3:0] next_fault;
	logic       major;
	logic       releasing;
	logic [7:0] gripper_state;
	logic [7:0] fault_codes;
	logic [31:0] blink_cnt;
	logic        blink_ph;

	grs_sync #(.W(3)) u_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    ({overtemp_i, undervolt_i, overcurrent_i}),
		.q_o    (pins_s)
	);
	assign overtemp_s  = pins_s[2];
	assign undervolt_s = pins_s[1];
	assign overcur_s   = pins_s[0];

	grs_timer #(.LIMIT(COMM_TIMEOUT)) u_comm (
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.clear_i   (comm_event_i),
		.expired_o (comm_lost)
	);

	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			act_q <= 1'b0;
		else
			act_q <= activate_request_i;
	end
	assign act_rise = activate_request_i && !act_q;

	// Motion state tracks activation; release forces it back to reset
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !activate_request_i)
			motion_state <= grs_pkg::MOT_RESET;
		else if (auto_release_i || major)
			motion_state <= grs_pkg::MOT_RESET;
		else if (act_rise)
			motion_state <= grs_pkg::MOT_ACTING;
		else if (motion_state == grs_pkg::MOT_ACTING && calib_done_i)
			motion_state <= grs_pkg::MOT_DONE;
	end

	// Object field is only meaningful with go-to set
	always_ff @(posedge clk_i) begin
		if (!rstn_i || !goto_request_i)
			object_detect_state <= grs_pkg::OBJ_MOVING;
		else if (moving_i)
			object_detect_state <= grs_pkg::OBJ_MOVING;
		else if (contact_i)
			object_detect_state <= closing_i ? grs_pkg::OBJ_CLOSE : grs_pkg::OBJ_OPEN;
		else
			object_detect_state <= grs_pkg::OBJ_AT_POS;
	end

	assign major = fault_code >= grs_pkg::FLT_MAJOR_MIN;

	always_ff @(posedge clk_i) begin
		if (!rstn_i || !activate_request_i)
			releasing <= 1'b0;
		else if (act_rise)
			releasing <= 1'b0;
		else if (auto_release_i)
			releasing <= 1'b1;
	end

	// Majors outrank minors and priority codes; a new major never replaces a held one
	// except the release finishing, which is the routine's own end state.
	always_comb begin
		next_fault = fault_code;
		if (major && !act_rise) begin
			if (fault_code == grs_pkg::FLT_REL_RUN && release_done_i)
				next_fault = grs_pkg::FLT_REL_DONE;
		end else if (releasing || auto_release_i)
			next_fault = release_done_i ? grs_pkg::FLT_REL_DONE : grs_pkg::FLT_REL_RUN;
		else if (undervolt_s)
			next_fault = grs_pkg::FLT_UNDERV;
		else if (internal_fault_i)
			next_fault = grs_pkg::FLT_INTERNAL;
		else if (act_fault_i)
			next_fault = grs_pkg::FLT_ACT_FAIL;
		else if (overcur_s)
			next_fault = grs_pkg::FLT_OVERCUR;
		else if (overtemp_s)
			next_fault = grs_pkg::FLT_TEMP;
		else if (comm_lost)
			next_fault = grs_pkg::FLT_NO_COMM;
		else if (goto_request_i && motion_state == grs_pkg::MOT_ACTING)
			next_fault = grs_pkg::FLT_DELAYED;
		else
			next_fault = grs_pkg::FLT_NONE;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			fault_code <= grs_pkg::FLT_NONE;
		else if (!activate_request_i)
			fault_code <= (goto_request_i || auto_release_i) ? grs_pkg::FLT_NO_ACT
				: grs_pkg::FLT_NONE;
		else
			fault_code <= next_fault;
	end

	assign gripper_state = {object_detect_state, motion_state, goto_request_i, 2'b00,
		activate_request_i};
	assign fault_codes = {external_controller_fault_i, fault_code};

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rd_data_o <= 8'h00;
		end else begin
			case (rd_addr_i)
				grs_pkg::OFF_STATE:    rd_data_o <= gripper_state;
				grs_pkg::OFF_FAULT:    rd_data_o <= fault_codes;
				grs_pkg::OFF_TGT_ECHO: rd_data_o <= position_request_i;
				grs_pkg::OFF_MEAS_POS: rd_data_o <= measured_position_i;
				grs_pkg::OFF_CURRENT:  rd_data_o <= motor_current_sample_i;
				default:               rd_data_o <= 8'h00;
			endcase
		end
	end

	localparam logic [1:0] GRS_FM_FRAGILE_V = grs_pkg::GRS_FM_FRAGILE;
	localparam logic [1:0] GRS_FM_LOW_V     = grs_pkg::GRS_FM_LOW;
	localparam logic [1:0] GRS_FM_HIGH_V    = grs_pkg::GRS_FM_HIGH;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			force_mode_o <= GRS_FM_FRAGILE_V;
			regrasp_en_o <= 1'b0;
		end else if (force_request_i == 8'h00) begin
			force_mode_o <= GRS_FM_FRAGILE_V;
			regrasp_en_o <= 1'b0;
		end else begin
			force_mode_o <= (force_request_i >= grs_pkg::FORCE_HIGH_MIN) ? GRS_FM_HIGH_V
				: GRS_FM_LOW_V;
			regrasp_en_o <= 1'b1;
		end
	end

	// Blink phase counter runs freely; cheap and keeps both colours visible
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			blink_cnt <= 32'h0;
			blink_ph  <= 1'b0;
		end else if (blink_cnt >= 32'(BLINK_HALF - 1)) begin
			blink_cnt <= 32'h0;
			blink_ph  <= !blink_ph;
		end else begin
			blink_cnt <= blink_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			led_red_o  <= 1'b0;
			led_blue_o <= 1'b1;
		end else if (major) begin
			led_red_o  <= blink_ph;
			led_blue_o <= !blink_ph;
		end else if (fault_code == grs_pkg::FLT_TEMP || fault_code == grs_pkg::FLT_NO_COMM) begin
			led_red_o  <= 1'b1;
			led_blue_o <= 1'b0;
		end else begin
			led_red_o  <= 1'b0;
			led_blue_o <= 1'b1;
		end
	end

	motion_no_two_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		motion_state != 2'h2) else $error("motion state code 2 produced");
	act_echo_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_addr_i == grs_pkg::OFF_STATE |=> rd_data_o[0] == $past(activate_request_i))
		else $error("activation echo wrong");
	goto_echo_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_addr_i == grs_pkg::OFF_STATE |=> rd_data_o[3] == $past(goto_request_i))
		else $error("go-to echo wrong");
	deact_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!activate_request_i && !goto_request_i && !auto_release_i |=> fault_code == 4'h0
		&& motion_state == 2'h0) else $error("deactivate did not clear");
	major_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		major && activate_request_i && act_q ##1 activate_request_i |-> major)
		else $error("major fault dropped early");
	contact_close_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		goto_request_i && !moving_i && contact_i && closing_i |=> object_detect_state == 2'h2)
		else $error("closing contact not reported");
	force_mode_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		force_request_i == 8'h00 |=> !regrasp_en_o && force_mode_o == 2'h0)
		else $error("fragile mode wrong");
	fault_byte_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_addr_i == grs_pkg::OFF_FAULT |=> rd_data_o == {$past(external_controller_fault_i),
		$past(fault_code)}) else $error("fault byte layout wrong");
	// Read port lags the address by one edge, so echoes compare against the sampled input
	pos_echo_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_addr_i == grs_pkg::OFF_TGT_ECHO |=> rd_data_o == $past(position_request_i))
		else $error("position echo wrong");
	meas_pos_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_addr_i == grs_pkg::OFF_MEAS_POS |=> rd_data_o == $past(measured_position_i))
		else $error("measured position wrong");
	current_byte_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_addr_i == grs_pkg::OFF_CURRENT |=> rd_data_o == $past(motor_current_sample_i))
		else $error("current byte wrong");
	force_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		force_request_i != 8'h00 && force_request_i < grs_pkg::FORCE_HIGH_MIN |=> regrasp_en_o
		&& force_mode_o == 2'h1) else $error("low torque mode wrong");
	force_high_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		force_request_i >= grs_pkg::FORCE_HIGH_MIN |=> regrasp_en_o && force_mode_o == 2'h2)
		else $error("high torque mode wrong");
	no_act_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!activate_request_i && goto_request_i |=> fault_code == grs_pkg::FLT_NO_ACT)
		else $error("unactivated action not flagged");
	minor_led_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		fault_code == grs_pkg::FLT_TEMP |=> led_red_o && !led_blue_o)
		else $error("overtemperature indicator wrong");
	major_led_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		major |=> led_red_o != led_blue_o)
		else $error("major fault indicator not alternating");
	rel_done_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		activate_request_i && fault_code == grs_pkg::FLT_REL_RUN && release_done_i
		|=> fault_code == grs_pkg::FLT_REL_DONE) else $error("release end not reported");
	act_seq_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		motion_state == 2'h1 ##[1:20] motion_state == 2'h3);
	release_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		fault_code == 4'hb ##[1:20] fault_code == 4'hf);
	grasp_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		object_detect_state == 2'h0 ##[1:20] object_detect_state == 2'h2);
	open_stop_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		object_detect_state == 2'h2 ##[1:20] object_detect_state == 2'h1);
	comm_lost_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
		fault_code == 4'h9 ##[1:40] fault_code == 4'h0);
endmodule : grs_status
`default_nettype wire

// ===== verilog/grs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module grs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,  // System clock
	input  wire logic         rstn_i, // Sync reset, active low
	input  wire logic [W-1:0] d_i,    // Asynchronous inputs
	output logic      [W-1:0] q_o     // Synchronised outputs
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : grs_sync
`default_nettype wire

// ===== verilog/grs_timer.sv
`timescale 1ns/1ps
`default_nettype none
module grs_timer #(
	parameter int LIMIT = 125000000
) (
	input  wire logic clk_i,   // System clock
	input  wire logic rstn_i,  // Sync reset, active low
	input  wire logic clear_i, // Restart the count
	output logic      expired_o // Held high once LIMIT cycles passed
);
	logic [31:0] count;

	always_ff @(posedge clk_i) begin
		if (!rstn_i || clear_i) begin
			count     <= 32'h0;
			expired_o <= 1'b0;
		end else if (count >= 32'(LIMIT - 1)) begin
			expired_o <= 1'b1;
		end else begin
			count <= count + 32'h1;
		end
	end
endmodule : grs_timer
`default_nettype wire
